// *** common/uart_ctrl_pkg.sv ***
package uart_ctrl_pkg;

  // register byte offsets on the APB window
  localparam logic [7:0] OFS_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h08;
  localparam logic [7:0] OFS_DATA       = 8'h0C;

  // serial_port_control field positions
  localparam int CTL_MODE_HI  = 7;
  localparam int CTL_MODE_LO  = 6;
  localparam int CTL_GATE     = 5;
  localparam int CTL_RX_EN    = 4;
  localparam int CTL_TX_NINTH = 3;
  localparam int CTL_RX_NINTH = 2;
  localparam int CTL_TX_DONE  = 1;
  localparam int CTL_RX_DONE  = 0;

  // interrupt status / mask field positions
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_TX_BIT = 1;

  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET     = 2'h0;
  localparam logic [7:0] DATA_RESET    = 8'h00;

  // operating modes from the two mode-select bits
  localparam logic [1:0] MODE_SHIFT     = 2'h0;
  localparam logic [1:0] MODE_UART8     = 2'h1;
  localparam logic [1:0] MODE_UART9_FIX = 2'h2;
  localparam logic [1:0] MODE_UART9_VAR = 2'h3;

  // mode 0 fixed divider: system cycles per half shift-clock period
  localparam logic [1:0] M0_HALF_DIV4 = 2'h2;
  localparam logic [1:0] M0_HALF_DIV2 = 2'h1;

  // last index of the eight data bits
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
    logic       stop_ok;
  } rx_frame_s;

endpackage : uart_ctrl_pkg

// *** rtl/frame_receiver.sv ***
`timescale 1ns/10ps
`default_nettype none

module frame_receiver
  import uart_ctrl_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      rst_b_in,
  input  wire logic      enable_in,
  input  wire logic      nine_bit_in,
  input  wire logic      tick_in,
  input  wire logic      rxd_in,
  output var  logic      done_out,
  output var  rx_frame_s frame_out
);

  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_NINTH, RX_STOP} rx_state_e;

  rx_state_e  state_ff;
  rx_state_e  nxt_state;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic       done_ff;
  logic       nxt_done;
  rx_frame_s  frame_ff;
  rx_frame_s  nxt_frame;

  assign done_out  = done_ff;
  assign frame_out = frame_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_done  = 1'b0;
    nxt_frame = frame_ff;
    if (!enable_in) begin
      nxt_state = RX_IDLE;
    end else if (tick_in) begin
      case (state_ff)
        RX_IDLE: begin
          if (!rxd_in) begin
            nxt_state = RX_DATA;
            nxt_cnt   = 3'h0;
          end
        end
        RX_DATA: begin
          nxt_frame.data = {rxd_in, frame_ff.data[7:1]};
          nxt_cnt        = cnt_ff + 3'h1;
          if (cnt_ff == LAST_DATA_BIT) begin
            nxt_state = nine_bit_in ? RX_NINTH : RX_STOP;
          end
        end
        RX_NINTH: begin
          nxt_frame.ninth = rxd_in;
          nxt_state       = RX_STOP;
        end
        RX_STOP: begin
          nxt_frame.stop_ok = rxd_in;
          nxt_done          = 1'b1;
          nxt_state         = RX_IDLE;
        end
        default: nxt_state = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= RX_IDLE;
      cnt_ff   <= 3'h0;
      done_ff  <= 1'b0;
      frame_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      done_ff  <= nxt_done;
      frame_ff <= nxt_frame;
    end
  end

endmodule : frame_receiver

`default_nettype wire

// *** rtl/uart_control_multiprocessor.sv ***
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - mode bits: 0 shift, 1 8-bit, 2/3 9-bit
// - modes 2/3 receive nine data bits, stop
// - modes 2/3 ninth bit lands in control field CTL_RX_NINTH
// - modes 2/3 gate set: flag only when ninth bit one
// - gate set: flag also needs address match
// - mode 1 gate: needs valid stop and match
// - mode 1 gate clear: stop bit stored
// - mode 0 clock idles at inverted gate
// - receiver runs only while enable set
// - mode 0 transmit-ninth selects timer overflow clock
module uart_control_multiprocessor
  import uart_ctrl_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output var  logic [31:0] prdata_out,
  output var  logic        pready_out,
  output var  logic        pslverr_out,
  input  wire logic        bit_tick_in,
  input  wire logic        timer1_ovf_in,
  input  wire logic        baud_doubler_in,
  input  wire logic        addr_match_in,
  input  wire logic        rxd_in,
  output var  logic        rxd_out,
  output var  logic        rxd_oe_out,
  output var  logic        txd_out,
  output var  logic        irq_out
);

  typedef enum logic [2:0] {TX_IDLE, TX_PEND, TX_START, TX_DATA, TX_NINTH, TX_STOP} tx_state_e;
  typedef enum logic [1:0] {M0_IDLE, M0_ACTIVE, M0_REST} m0_state_e;

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0]  control_ff;
  logic [7:0]  nxt_control;
  logic [1:0]  status_ff;
  logic [1:0]  nxt_status;
  logic [1:0]  mask_ff;
  logic [1:0]  nxt_mask;
  logic [7:0]  rx_buf_ff;
  logic [7:0]  nxt_rx_buf;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        nxt_pslverr;
  logic        irq_ff;
  logic        txd_ff;
  logic        nxt_txd;
  logic        rxd_out_ff;
  logic        nxt_rxd_out;
  logic        rxd_oe_ff;
  logic        nxt_rxd_oe;

  tx_state_e   tx_state_ff;
  tx_state_e   nxt_tx_state;
  logic [7:0]  tx_shift_ff;
  logic [7:0]  nxt_tx_shift;
  logic [2:0]  tx_cnt_ff;
  logic [2:0]  nxt_tx_cnt;

  m0_state_e   m0_state_ff;
  m0_state_e   nxt_m0_state;
  logic [7:0]  m0_shift_ff;
  logic [7:0]  nxt_m0_shift;
  logic [2:0]  m0_cnt_ff;
  logic [2:0]  nxt_m0_cnt;
  logic        m0_rx_ff;
  logic        nxt_m0_rx;
  logic [1:0]  m0_div_ff;
  logic [1:0]  nxt_m0_div;

  logic        rx_done;
  rx_frame_s   rx_frame;

  ////////////////////////////////////////////////////////////////////////////////
  // control field decode

  wire [1:0] mode     = {control_ff[CTL_MODE_HI], control_ff[CTL_MODE_LO]};
  wire       gate     = control_ff[CTL_GATE];
  wire       rx_en    = control_ff[CTL_RX_EN];
  wire       tx_ninth = control_ff[CTL_TX_NINTH];
  wire       shift_md = (mode == MODE_SHIFT);
  wire       nine_md  = (mode == MODE_UART9_FIX) || (mode == MODE_UART9_VAR);
  wire       byte_md  = (mode == MODE_UART8);

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire       setup      = psel_in && !penable_in;
  wire       access     = psel_in && penable_in && pready_ff;
  wire       wr         = access && pwrite_in;
  wire       hit_ctl    = (paddr_in == OFS_CONTROL);
  wire       hit_sts    = (paddr_in == OFS_IRQ_STATUS);
  wire       hit_mask   = (paddr_in == OFS_IRQ_MASK);
  wire       hit_data   = (paddr_in == OFS_DATA);
  wire       hit_any    = hit_ctl || hit_sts || hit_mask || hit_data;
  wire       wr_ctl     = wr && hit_ctl;
  wire       wr_sts     = wr && hit_sts;
  wire       wr_mask    = wr && hit_mask;
  wire       wr_data    = wr && hit_data;

  wire [7:0] ctl_view   = {control_ff[7:2], status_ff[IRQ_TX_BIT], status_ff[IRQ_RX_BIT]};
  wire [7:0] rd_byte    = hit_ctl  ? ctl_view :
                          hit_sts  ? {6'h00, status_ff} :
                          hit_mask ? {6'h00, mask_ff} :
                          hit_data ? rx_buf_ff : 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // receive acceptance for the framed modes

  // the address compare lives outside; it must be valid when the frame ends
  wire       addr_hit   = addr_match_in;
  wire       acc_nine   = !gate || (rx_frame.ninth && addr_hit);
  wire       acc_byte   = !gate || (rx_frame.stop_ok && addr_hit);
  wire       async_ok   = nine_md ? acc_nine : acc_byte;
  wire       async_rx   = rx_done && !shift_md && async_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // mode 0 shift engine timing

  wire [1:0] m0_half    = baud_doubler_in ? M0_HALF_DIV2 : M0_HALF_DIV4;
  wire       div_wrap   = (m0_div_ff == (m0_half - 2'h1));
  // timer overflow replaces the fixed divider when the transmit-ninth bit is set
  wire       m0_tick    = tx_ninth ? timer1_ovf_in : div_wrap;
  wire       m0_busy    = (m0_state_ff != M0_IDLE);
  wire       m0_last    = (m0_cnt_ff == LAST_DATA_BIT);
  wire       m0_end     = (m0_state_ff == M0_REST) && m0_tick && m0_last;
  wire       m0_tx_done = m0_end && !m0_rx_ff;
  wire       m0_rx_done = m0_end && m0_rx_ff;
  // reception in mode 0 starts once enabled and the previous byte was taken
  wire       m0_rx_go   = shift_md && !m0_busy && rx_en && !status_ff[IRQ_RX_BIT] &&
                          !wr_data;
  wire       m0_tx_go   = shift_md && !m0_busy && wr_data;

  ////////////////////////////////////////////////////////////////////////////////
  // framed transmitter

  wire       tx_busy    = (tx_state_ff != TX_IDLE);
  wire       tx_go      = !shift_md && !tx_busy && wr_data;
  // the done flag rises as the stop bit begins
  wire       tx_at_stop = bit_tick_in && (nxt_tx_state == TX_STOP) &&
                          (tx_state_ff != TX_STOP);

  always_comb begin
    nxt_tx_state = tx_state_ff;
    nxt_tx_shift = tx_shift_ff;
    nxt_tx_cnt   = tx_cnt_ff;
    if (tx_go) begin
      nxt_tx_state = TX_PEND;
      nxt_tx_shift = pwdata_in[7:0];
    end else if (shift_md) begin
      nxt_tx_state = TX_IDLE;
    end else if (bit_tick_in) begin
      case (tx_state_ff)
        TX_IDLE:  nxt_tx_state = TX_IDLE;
        TX_PEND:  nxt_tx_state = TX_START;
        TX_START: begin
          nxt_tx_state = TX_DATA;
          nxt_tx_cnt   = 3'h0;
        end
        TX_DATA: begin
          if (tx_cnt_ff == LAST_DATA_BIT) begin
            nxt_tx_state = nine_md ? TX_NINTH : TX_STOP;
          end else begin
            nxt_tx_cnt   = tx_cnt_ff + 3'h1;
            nxt_tx_shift = {1'b0, tx_shift_ff[7:1]};
          end
        end
        TX_NINTH: nxt_tx_state = TX_STOP;
        TX_STOP:  nxt_tx_state = TX_IDLE;
        default:  nxt_tx_state = TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mode 0 engine

  always_comb begin
    nxt_m0_state = m0_state_ff;
    nxt_m0_shift = m0_shift_ff;
    nxt_m0_cnt   = m0_cnt_ff;
    nxt_m0_rx    = m0_rx_ff;
    nxt_m0_div   = (m0_busy && !div_wrap) ? (m0_div_ff + 2'h1) : 2'h0;
    if (!shift_md) begin
      nxt_m0_state = M0_IDLE;
    end else if (m0_tx_go || m0_rx_go) begin
      nxt_m0_state = M0_ACTIVE;
      nxt_m0_shift = m0_tx_go ? pwdata_in[7:0] : 8'h00;
      nxt_m0_cnt   = 3'h0;
      nxt_m0_rx    = m0_rx_go;
    end else if (m0_tick) begin
      case (m0_state_ff)
        M0_IDLE:   nxt_m0_state = M0_IDLE;
        M0_ACTIVE: begin
          nxt_m0_state = M0_REST;
          if (m0_rx_ff) begin
            nxt_m0_shift = {rxd_in, m0_shift_ff[7:1]};
          end
        end
        M0_REST: begin
          if (m0_last) begin
            nxt_m0_state = M0_IDLE;
          end else begin
            nxt_m0_state = M0_ACTIVE;
            nxt_m0_cnt   = m0_cnt_ff + 3'h1;
            if (!m0_rx_ff) begin
              nxt_m0_shift = {1'b0, m0_shift_ff[7:1]};
            end
          end
        end
        default: nxt_m0_state = M0_IDLE;
      endcase
    end
    // clearing the enable abandons a mode 0 reception in progress
    if (m0_rx_ff && !rx_en && m0_busy) begin
      nxt_m0_state = M0_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin outputs

  always_comb begin
    nxt_rxd_out = 1'b1;
    nxt_rxd_oe  = 1'b0;
    if (shift_md) begin
      // the clock sits at the inverse of the gate bit whenever it is not pulsing
      nxt_txd = (nxt_m0_state == M0_ACTIVE) ? gate : !gate;
      if (m0_busy && !nxt_m0_rx && (nxt_m0_state != M0_IDLE)) begin
        nxt_rxd_out = nxt_m0_shift[0];
        nxt_rxd_oe  = 1'b1;
      end
    end else begin
      case (nxt_tx_state)
        TX_START: nxt_txd = 1'b0;
        TX_DATA:  nxt_txd = nxt_tx_shift[0];
        TX_NINTH: nxt_txd = tx_ninth;
        default:  nxt_txd = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers, flags and bus answer

  wire       rx_set  = async_rx || m0_rx_done;
  wire       tx_set  = tx_at_stop || m0_tx_done;
  wire [1:0] w1c     = wr_sts ? pwdata_in[1:0] : 2'h0;
  wire [1:0] ev_set  = {tx_set, rx_set};

  always_comb begin
    // a hardware set in the same cycle as a clear wins
    nxt_status = ev_set | (status_ff & ~w1c);
    nxt_mask   = wr_mask ? pwdata_in[1:0] : mask_ff;
    nxt_control = control_ff;
    if (wr_ctl) begin
      nxt_control[7:3] = pwdata_in[7:3];
    end
    if (rx_done && nine_md) begin
      nxt_control[CTL_RX_NINTH] = rx_frame.ninth;
    end else if (rx_done && byte_md && !gate) begin
      nxt_control[CTL_RX_NINTH] = rx_frame.stop_ok;
    end
    nxt_control[1:0] = 2'h0;
    nxt_rx_buf  = async_rx ? rx_frame.data : m0_rx_done ? m0_shift_ff : rx_buf_ff;
    nxt_prdata  = (setup && !pwrite_in) ? {24'h000000, rd_byte} : 32'h00000000;
    nxt_pslverr = setup && !hit_any;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      control_ff  <= CONTROL_RESET;
      status_ff   <= IRQ_RESET;
      mask_ff     <= IRQ_RESET;
      rx_buf_ff   <= DATA_RESET;
      prdata_ff   <= 32'h00000000;
      pready_ff   <= 1'b0;
      pslverr_ff  <= 1'b0;
      irq_ff      <= 1'b0;
    end else begin
      control_ff  <= nxt_control;
      status_ff   <= nxt_status;
      mask_ff     <= nxt_mask;
      rx_buf_ff   <= nxt_rx_buf;
      prdata_ff   <= nxt_prdata;
      pready_ff   <= setup;
      pslverr_ff  <= nxt_pslverr;
      irq_ff      <= |(nxt_status & nxt_mask);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_state_ff <= TX_IDLE;
      tx_shift_ff <= 8'h00;
      tx_cnt_ff   <= 3'h0;
      m0_state_ff <= M0_IDLE;
      m0_shift_ff <= 8'h00;
      m0_cnt_ff   <= 3'h0;
      m0_rx_ff    <= 1'b0;
      m0_div_ff   <= 2'h0;
    end else begin
      tx_state_ff <= nxt_tx_state;
      tx_shift_ff <= nxt_tx_shift;
      tx_cnt_ff   <= nxt_tx_cnt;
      m0_state_ff <= nxt_m0_state;
      m0_shift_ff <= nxt_m0_shift;
      m0_cnt_ff   <= nxt_m0_cnt;
      m0_rx_ff    <= nxt_m0_rx;
      m0_div_ff   <= nxt_m0_div;
    end
  end

  // reset leaves mode 0 selected with the gate clear, so the clock idles high
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      txd_ff     <= 1'b1;
      rxd_out_ff <= 1'b1;
      rxd_oe_ff  <= 1'b0;
    end else begin
      txd_ff     <= nxt_txd;
      rxd_out_ff <= nxt_rxd_out;
      rxd_oe_ff  <= nxt_rxd_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // framed receiver

  frame_receiver i_frame_receiver (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .enable_in   (rx_en && !shift_md),
    .nine_bit_in (nine_md),
    .tick_in     (bit_tick_in),
    .rxd_in      (rxd_in),
    .done_out    (rx_done),
    .frame_out   (rx_frame)
  );

  assign prdata_out  = prdata_ff;
  assign pready_out  = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign irq_out     = irq_ff;
  assign txd_out     = txd_ff;
  assign rxd_out     = rxd_out_ff;
  assign rxd_oe_out  = rxd_oe_ff;

endmodule : uart_control_multiprocessor

`default_nettype wire

// *** dv/uart_control_multiprocessor_checker.sv ***
`timescale 1ns/10ps
`default_nettype none

module uart_control_multiprocessor_checker
  import uart_ctrl_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [31:0] prdata_out,
  input  wire logic        pready_out,
  input  wire logic        pslverr_out,
  input  wire logic        timer1_ovf_in,
  input  wire logic        rxd_oe_out,
  input  wire logic        txd_out,
  input  wire logic        irq_out
);
  logic [7:0] ctl_ff;
  logic [1:0] mask_ff;
  logic [5:0] quiet_ff;
  wire  logic commit_w = psel_in & penable_in & pready_out & pwrite_in;
  wire  logic mapped_w = paddr_in inside {OFS_CONTROL, OFS_IRQ_STATUS, OFS_IRQ_MASK, OFS_DATA};
  wire  logic irq_wr_w = commit_w && (paddr_in == OFS_IRQ_STATUS || paddr_in == OFS_IRQ_MASK);
  wire  logic cfg_wr_w = commit_w && (paddr_in == OFS_CONTROL || paddr_in == OFS_DATA);

  // shadow of the control and mask words; quiet counts cycles since a control or data write
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctl_ff   <= CONTROL_RESET;
      mask_ff  <= IRQ_RESET;
      quiet_ff <= 6'h00;
    end else begin
      if (commit_w && paddr_in == OFS_CONTROL) ctl_ff <= pwdata_in[7:0];
      if (commit_w && paddr_in == OFS_IRQ_MASK) mask_ff <= pwdata_in[1:0];
      quiet_ff <= cfg_wr_w ? 6'h00 : (quiet_ff == 6'h3F ? quiet_ff : quiet_ff + 6'h01);
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  ready_answer_a: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready in access cycle");
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready stood more than one cycle");
  error_map_a: assert property (pready_out |-> pslverr_out == !mapped_w)
    else $error("error response does not follow address map");
  rdata_quiet_a: assert property (!(pready_out && !pwrite_in) |-> prdata_out == 32'h0)
    else $error("read data outside read access");
  rdata_upper_a: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
    else $error("upper read data bits set");
  irq_fall_a: assert property ($fell(irq_out) |-> $past(irq_wr_w) || $past(irq_wr_w, 2))
    else $error("interrupt dropped without software write");
  irq_mask_a: assert property (irq_out |-> mask_ff != 2'h0 || $past(mask_ff) != 2'h0)
    else $error("interrupt with all sources masked");
  oe_mode_a: assert property (rxd_oe_out && quiet_ff > 6'h02 |-> ctl_ff[7:6] == MODE_SHIFT)
    else $error("data pin driven outside shift mode");
  idle_clock_a: assert property (ctl_ff[7:6] == MODE_SHIFT && !ctl_ff[CTL_RX_EN]
      && !ctl_ff[CTL_TX_NINTH] && quiet_ff > 6'h28 |-> txd_out == !ctl_ff[CTL_GATE])
    else $error("shift clock idle level wrong");
  // tick-to-pin latency is one register stage, yet the check looks back three cycles
  timer_clock_a: assert property (ctl_ff[7:6] == MODE_SHIFT && ctl_ff[CTL_TX_NINTH]
      && quiet_ff > 6'h03 && $changed(txd_out)
      |-> $past(timer1_ovf_in) || $past(timer1_ovf_in, 2) || $past(timer1_ovf_in, 3))
    else $error("shift clock moved without timer overflow");
endmodule : uart_control_multiprocessor_checker

bind uart_control_multiprocessor uart_control_multiprocessor_checker i_chk (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .timer1_ovf_in(timer1_ovf_in),
  .rxd_oe_out(rxd_oe_out), .txd_out(txd_out), .irq_out(irq_out));

`default_nettype wire

// *** dv/serial_peer_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module serial_peer_model (
  input  wire logic clk_in,
  output var  logic tick_out,
  output var  logic line_out
);
  logic [1:0] div_ff;

  // line has a pull-up, so it idles high between frames
  initial begin
    div_ff   = 2'h0;
    tick_out = 1'h0;
    line_out = 1'h1;
  end

  always @(posedge clk_in) begin
    div_ff   <= div_ff + 2'h1;
    tick_out <= (div_ff == 2'h2);
  end

  // bits go out lsb first; caller builds start, data, ninth (address one, data zero), stop
  task automatic send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in iff tick_out);
      line_out <= bits[i];
    end
    @(posedge clk_in iff tick_out);
    line_out <= 1'h1;
  endtask : send
endmodule : serial_peer_model

`default_nettype wire

// *** dv/tb_uart_control_multiprocessor.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp=%h got=%h", n, e, g); end end

module tb_uart_control_multiprocessor;
  import uart_ctrl_pkg::*;
  logic        clk_in = 1'h0;
  logic        rst_b_in, psel_in, penable_in, pwrite_in, timer1_ovf_in, addr_match_in;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic        pready_out, pslverr_out, rxd_out, rxd_oe_out, txd_out, irq_out;
  logic        tick_w, line_w, err_q;
  wire  logic  rxd_w = rxd_oe_out ? rxd_out : line_w;
  int          err_count, compares, cycles;
  logic [7:0]  m0_bits;

  // shift-register peripheral: takes the data pin on each rising shift clock
  always @(posedge txd_out) begin
    if (rxd_oe_out) m0_bits = {rxd_out, m0_bits[7:1]};
  end

  always #20 clk_in = ~clk_in;

  uart_control_multiprocessor i_uart_control_multiprocessor (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .bit_tick_in(tick_w), .timer1_ovf_in(timer1_ovf_in), .baud_doubler_in(1'h0),
    .addr_match_in(addr_match_in), .rxd_in(rxd_w), .rxd_out(rxd_out),
    .rxd_oe_out(rxd_oe_out), .txd_out(txd_out), .irq_out(irq_out));

  serial_peer_model i_serial_peer_model (.clk_in(clk_in), .tick_out(tick_w), .line_out(line_w));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in <= 1'h1;
    penable_in <= 1'h0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'h1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'h1 && n < 20);
    rd = prdata_out;
    err_q = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask : apb

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask : rdchk

  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [2:0] f);
    return {24'h0, m, f, 3'h0};
  endfunction : ctl

  // f packs gate, enable, ninth, stop, match, expected flag, expected ninth
  task automatic rx_case(input logic [1:0] m, input logic [7:0] d, input logic [6:0] f);
    apb(1'h1, OFS_CONTROL, ctl(m, {f[6:5], 1'h0}));
    addr_match_in <= f[2];
    if (m[1]) i_serial_peer_model.send({f[3], f[4], d, 1'h0}, 11);
    else i_serial_peer_model.send({1'h0, f[3], d, 1'h0}, 10);
    repeat (4) @(posedge clk_in);
    rdchk("rx status", OFS_IRQ_STATUS, {31'h0, f[1]});
    apb(1'h0, OFS_CONTROL, 32'h0);
    `CHK("rx ninth", f[0], rd[CTL_RX_NINTH])
    if (f[1]) rdchk("rx data", OFS_DATA, {24'h0, d});
    apb(1'h1, OFS_IRQ_STATUS, 32'h3);
  endtask : rx_case

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk("ctl reset", OFS_CONTROL, {24'h0, CONTROL_RESET});
    rdchk("mask reset", OFS_IRQ_MASK, 32'h0);
    rdchk("unmapped", 8'h10, 32'h0);
    `CHK("slverr", 1'h1, err_q)
    `CHK("txd idle", 1'h1, txd_out)
    $display("test reset done");
  endtask : t_reset

  task automatic t_frames;
    rx_case(2'h2, 8'hA5, 7'h3B);
    rx_case(2'h3, 8'h3C, 7'h2A);
    rx_case(2'h3, 8'h5A, 7'h6C);
    rx_case(2'h3, 8'h11, 7'h79);
    rx_case(2'h3, 8'h22, 7'h7F);
    rx_case(2'h1, 8'h33, 7'h65);
    rx_case(2'h1, 8'h44, 7'h69);
    rx_case(2'h1, 8'h55, 7'h6F);
    rx_case(2'h2, 8'h66, 7'h2A);
    rx_case(2'h1, 8'h77, 7'h2B);
    rx_case(2'h1, 8'h88, 7'h0D);
    $display("test frames done");
  endtask : t_frames

  task automatic t_irq;
    apb(1'h1, OFS_IRQ_MASK, 32'h1);
    apb(1'h1, OFS_CONTROL, ctl(2'h1, 3'h2));
    i_serial_peer_model.send({1'h0, 1'h1, 8'h9C, 1'h0}, 10);
    repeat (4) @(posedge clk_in);
    `CHK("irq set", 1'h1, irq_out)
    apb(1'h1, OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk_in);
    `CHK("irq masked", 1'h0, irq_out)
    rdchk("status sticky", OFS_IRQ_STATUS, 32'h1);
    apb(1'h1, OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk_in);
    `CHK("irq unmasked", 1'h1, irq_out)
    apb(1'h1, OFS_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clk_in);
    `CHK("irq cleared", 1'h0, irq_out)
    rdchk("status cleared", OFS_IRQ_STATUS, 32'h0);
    $display("test irq done");
  endtask : t_irq

  task automatic t_tx;
    logic [10:0] seen;
    apb(1'h1, OFS_CONTROL, ctl(2'h3, 3'h1));
    apb(1'h1, OFS_DATA, 32'h5A);
    @(negedge txd_out);
    // one look per bit time; each bit stands from one tick to the next
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_in iff tick_w);
      seen[i] = txd_out;
    end
    `CHK("tx frame", 11'h6B4, seen)
    rdchk("tx status", OFS_IRQ_STATUS, 32'h2);
    apb(1'h1, OFS_IRQ_STATUS, 32'h3);
    $display("test transmit done");
  endtask : t_tx

  task automatic t_mode0;
    apb(1'h1, OFS_CONTROL, ctl(2'h0, 3'h4));
    repeat (4) @(posedge clk_in);
    `CHK("clock idle low", 1'h0, txd_out)
    apb(1'h1, OFS_CONTROL, ctl(2'h0, 3'h1));
    repeat (4) @(posedge clk_in);
    `CHK("clock idle high", 1'h1, txd_out)
    apb(1'h1, OFS_DATA, 32'hC3);
    repeat (20) @(posedge clk_in);
    // the first half bit parks the clock at its active level until an overflow
    `CHK("clock held", 1'h0, txd_out)
    rdchk("tx pending", OFS_IRQ_STATUS, 32'h0);
    // forty overflows is well past the sixteen half bits a byte needs
    repeat (40) begin
      @(posedge clk_in);
      timer1_ovf_in <= 1'h1;
      @(posedge clk_in);
      timer1_ovf_in <= 1'h0;
    end
    repeat (4) @(posedge clk_in);
    rdchk("tx done", OFS_IRQ_STATUS, 32'h2);
    `CHK("shift data", 8'hC3, m0_bits)
    apb(1'h1, OFS_IRQ_STATUS, 32'h3);
    // idle line reads as all ones through the pull-up
    apb(1'h1, OFS_CONTROL, ctl(2'h0, 3'h2));
    repeat (40) @(posedge clk_in);
    rdchk("m0 rx flag", OFS_IRQ_STATUS, 32'h1);
    rdchk("m0 rx data", OFS_DATA, 32'hFF);
    $display("test shift mode done");
  endtask : t_mode0

  task automatic report_and_stop;
    $display("compares=%0d mismatches=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk_in) begin
    cycles++;
    if (cycles > 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  initial begin
    rst_b_in = 1'h0;
    psel_in = 1'h0;
    penable_in = 1'h0;
    pwrite_in = 1'h0;
    paddr_in = 8'h00;
    pwdata_in = 32'h0;
    timer1_ovf_in = 1'h0;
    addr_match_in = 1'h0;
    err_count = 0;
    compares = 0;
    cycles = 0;
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'h1;
    t_reset();
    t_frames();
    t_irq();
    t_tx();
    t_mode0();
    report_and_stop();
  end
endmodule : tb_uart_control_multiprocessor

`default_nettype wire
